// file: gcfg_top.sv
// General configuration, lead-off and bias register block behind APB
`timescale 1ns/1ps
module gcfg_top
   import gcfg_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        imp_over_range_in,
   input  wire logic        imp_under_range_in,
   input  wire logic        dc_leadoff_in,
   output gcfg_ctrl_t       ctrl_q,
   output gcfg_analog_t     analog_q,
   output logic             cardiac_power_q,
   output logic             impedance_power_q,
   output logic             beat_detect_allowed_q,
   output logic             irq
);
   logic [23:0]  gen_q;
   logic [23:0]  gen_wr;
   logic [2:0]   stat_q;
   logic [2:0]   mask_q;
   logic [2:0]   rate_sel_q;
   logic [2:0]   ev;
   logic [1:0]   ovr_s;
   logic [1:0]   und_s;
   logic [1:0]   dc_s;
   logic         wr_acc;
   logic         rd_acc;
   logic         hit;
   logic [31:0]  rd_mux;
   logic [31:0]  mstr_freq;
   logic [31:0]  card_rate;
   logic [31:0]  imp_rate;
   logic [31:0]  beat_res;
   logic [31:0]  calibration_time_resolution;
   logic         card_en;
   logic         imp_en;
   logic [1:0]   dlo;
   logic [1:0]   dce;
   logic [2:0]   mag;
   logic [1:0]   rbm;

   // Single-cycle access phase: pready is held high
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && !penable && !pwrite;

   // Write value with the bias gating applied
   always_comb begin
      gen_wr = (pwdata[23:0] & GCFG_WR_MASK) | (gen_q & ~GCFG_WR_MASK);
      unique case (gen_wr[GCFG_RBM_LSB +: 2])
         GCFG_RBM_CARD: begin
            // Enable may already be held or arrive in this same write
            if (!gen_wr[GCFG_BIT_CARD_EN] && !gen_q[GCFG_BIT_CARD_EN]) begin
               gen_wr[GCFG_RBM_LSB +: 2] = GCFG_RBM_OFF;
            end
         end
         GCFG_RBM_IMP: begin
            if (!gen_wr[GCFG_BIT_IMP_EN] && !gen_q[GCFG_BIT_IMP_EN]) begin
               gen_wr[GCFG_RBM_LSB +: 2] = GCFG_RBM_OFF;
            end
         end
         default: begin
         end
      endcase
   end

   // General configuration register, upper bits beyond 21 not held here
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gen_q <= GCFG_RESET_VAL;
      end else if (wr_acc && paddr == GCFG_ADDR_GENERAL) begin
         gen_q <= gen_wr;
      end
   end

   // Clearing the enable leaves the stored bias mode in place; it just stops acting
   assign card_en = gen_q[GCFG_BIT_CARD_EN];
   assign imp_en  = gen_q[GCFG_BIT_IMP_EN];
   assign dlo     = gen_q[GCFG_DLO_LSB +: 2];
   assign dce     = gen_q[GCFG_DCE_LSB +: 2];
   assign mag     = gen_q[GCFG_MAG_LSB +: 3];
   assign rbm     = gen_q[GCFG_RBM_LSB +: 2];

   // Rate selection bits: [1:0] cardiac rate code, [2] impedance rate code
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rate_sel_q <= '0;
      end else if (wr_acc && paddr == GCFG_ADDR_RATE_SEL) begin
         rate_sel_q <= pwdata[2:0];
      end
   end

   gcfg_rate_table u_rate (
      .pclk                          (pclk),
      .presetn                       (presetn),
      .master_clock_select           (gen_q[GCFG_MCS_LSB +: 2]),
      .cardiac_sample_rate_code      (rate_sel_q[1:0]),
      .impedance_rate_code           (rate_sel_q[2]),
      .master_freq_q                 (mstr_freq),
      .cardiac_rate_q                (card_rate),
      .impedance_rate_q              (imp_rate),
      .beat_interval_resolution_q    (beat_res),
      .calibration_time_resolution_q (calibration_time_resolution)
   );

   // Comparator inputs come from the analog side, so synchronise them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovr_s <= '0;
         und_s <= '0;
         dc_s  <= '0;
      end else begin
         ovr_s <= {ovr_s[0], imp_over_range_in};
         und_s <= {und_s[0], imp_under_range_in};
         dc_s  <= {dc_s[0], dc_leadoff_in};
      end
   end

   // Detection events gated by their mode and channel activity
   always_comb begin
      ev = '0;
      ev[GCFG_IRQ_OVER]  = imp_en && dlo[1] && ovr_s[1];
      ev[GCFG_IRQ_UNDER] = imp_en && dlo[0] && und_s[1];
      ev[GCFG_IRQ_DC]    = card_en && dce == GCFG_DCE_ON && dc_s[1];
   end

   // Sticky status, write one to clear; a new event wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q <= '0;
      end else begin
         if (wr_acc && paddr == GCFG_ADDR_IRQ_STAT) begin
            stat_q <= (stat_q & ~pwdata[2:0]) | ev;
         end else begin
            stat_q <= stat_q | ev;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= '0;
      end else if (wr_acc && paddr == GCFG_ADDR_IRQ_MASK) begin
         mask_q <= pwdata[2:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(stat_q & mask_q);
      end
   end

   // Decoded outputs to the analog front end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q                <= '0;
         analog_q              <= '0;
         cardiac_power_q       <= 1'b0;
         impedance_power_q     <= 1'b0;
         beat_detect_allowed_q <= 1'b0;
      end else begin
         // Bits 17:16 are unused and skipped in the control copy
         ctrl_q                <= {gen_q[19:18], gen_q[15:0]};
         cardiac_power_q       <= card_en;
         impedance_power_q     <= imp_en;
         beat_detect_allowed_q <= card_en;
         analog_q.over_detect  <= imp_en && dlo[1];
         analog_q.under_detect <= imp_en && dlo[0];
         analog_q.dc_detect    <= card_en && dce == GCFG_DCE_ON;
         // Reserved magnitudes are treated as disconnected
         analog_q.sources_on   <= mag != GCFG_MAG_OFF && mag <= GCFG_MAG_MAX;
         analog_q.pullup_pos   <= mag != GCFG_MAG_OFF && mag <= GCFG_MAG_MAX
                                  && !gen_q[GCFG_BIT_IPOL];
         analog_q.bias_card    <= rbm == GCFG_RBM_CARD && card_en;
         analog_q.bias_imp     <= rbm == GCFG_RBM_IMP && imp_en;
      end
   end

   // Read data for selected address
   always_comb begin
      hit    = 1'b1;
      rd_mux = '0;
      unique case (paddr)
         GCFG_ADDR_GENERAL:   rd_mux = {8'h00, gen_q};
         GCFG_ADDR_IRQ_STAT:  rd_mux = {29'h0, stat_q};
         GCFG_ADDR_IRQ_MASK:  rd_mux = {29'h0, mask_q};
         GCFG_ADDR_RATE_SEL:  rd_mux = {29'h0, rate_sel_q};
         GCFG_ADDR_RATE_INFO: rd_mux = card_rate;
         GCFG_ADDR_TIMING:    rd_mux = paddr[0] ? calibration_time_resolution : beat_res;
         12'h054:             rd_mux = imp_rate;
         12'h058:             rd_mux = mstr_freq;
         12'h05c:             rd_mux = calibration_time_resolution;
         default:             hit    = 1'b0;
      endcase
   end

   // Read data captured in setup so it is stable from a flop in access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pslverr <= 1'b0;
         pready  <= 1'b0;
      end else begin
         pready <= 1'b1;
         if (psel && !penable) begin
            prdata  <= rd_acc ? rd_mux : '0;
            pslverr <= !hit;
         end
      end
   end

   AST_BIAS_GATE: assert property (@(posedge pclk) disable iff (!presetn)
      rbm == GCFG_RBM_CARD |-> card_en || $past(card_en) || $past(rbm) == GCFG_RBM_CARD)
      else $error("bias mode set without cardiac enable");
   AST_GATE_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == GCFG_ADDR_GENERAL && pwdata[GCFG_RBM_LSB +: 2] == GCFG_RBM_IMP
      && !pwdata[GCFG_BIT_IMP_EN] && !imp_en
      |=> gen_q[5:4] == GCFG_RBM_OFF)
      else $error("ungated bias mode stored");
   AST_READBACK: assert property (@(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == GCFG_ADDR_GENERAL
      |=> {gen_q[21:18], gen_q[15:6]} == $past({pwdata[21:18], pwdata[15:6]}))
      else $error("general field readback mismatch");
   AST_DC_GATE: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(stat_q[GCFG_IRQ_DC]) |-> $past(card_en) && $past(dce) == GCFG_DCE_ON)
      else $error("dc flag set while gated off");
   AST_OVER_GATE: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(stat_q[GCFG_IRQ_OVER]) |-> $past(imp_en) && $past(dlo[1]))
      else $error("over flag set while gated off");
   AST_UNDER_GATE: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(stat_q[GCFG_IRQ_UNDER]) |-> $past(imp_en) && $past(dlo[0]))
      else $error("under flag set while gated off");
   AST_IMP_POWER: assert property (@(posedge pclk) disable iff (!presetn)
      imp_en |=> impedance_power_q)
      else $error("impedance power not following enable");
   AST_CARD_POWER: assert property (@(posedge pclk) disable iff (!presetn)
      !card_en |=> !beat_detect_allowed_q && !analog_q.bias_card)
      else $error("cardiac functions on while disabled");
   AST_RATE: assert property (@(posedge pclk) disable iff (!presetn)
      gen_q[21:20] == 2'h0 && rate_sel_q == 3'h0 ##1 $stable(gen_q) && $stable(rate_sel_q)
      |-> card_rate == 32'd512000 && beat_res == 32'd7812500)
      else $error("rate table mismatch");
   AST_POLARITY: assert property (@(posedge pclk) disable iff (!presetn)
      mag == GCFG_MAG_OFF |=> !analog_q.pullup_pos && !analog_q.sources_on)
      else $error("current sources on while disconnected");
endmodule

// file: gcfg_pkg.sv
// Package with register map, field layout and rate table constants
package gcfg_pkg;
   localparam logic [11:0] GCFG_ADDR_GENERAL   = 12'h010;
   localparam logic [11:0] GCFG_ADDR_IRQ_STAT  = 12'h040;
   localparam logic [11:0] GCFG_ADDR_IRQ_MASK  = 12'h044;
   localparam logic [11:0] GCFG_ADDR_RATE_SEL  = 12'h048;
   localparam logic [11:0] GCFG_ADDR_RATE_INFO = 12'h04c;
   localparam logic [11:0] GCFG_ADDR_TIMING    = 12'h050;

   localparam int GCFG_BIT_CARD_EN = 19;
   localparam int GCFG_BIT_IMP_EN  = 18;
   localparam int GCFG_BIT_IPOL    = 11;
   localparam int GCFG_BIT_POS_B   = 1;
   localparam int GCFG_BIT_NEG_B   = 0;
   localparam int GCFG_MCS_LSB     = 20;
   localparam int GCFG_DLO_LSB     = 14;
   localparam int GCFG_DCE_LSB     = 12;
   localparam int GCFG_MAG_LSB     = 8;
   localparam int GCFG_VTH_LSB     = 6;
   localparam int GCFG_RBM_LSB     = 4;
   localparam int GCFG_RBV_LSB     = 2;

   localparam logic [23:0] GCFG_WR_MASK   = 24'h3cffff;
   localparam logic [23:0] GCFG_RESET_VAL = 24'h000004;

   localparam logic [1:0] GCFG_RBM_OFF  = 2'h0;
   localparam logic [1:0] GCFG_RBM_CARD = 2'h1;
   localparam logic [1:0] GCFG_RBM_IMP  = 2'h2;
   localparam logic [1:0] GCFG_DCE_ON   = 2'h1;
   localparam logic [2:0] GCFG_MAG_OFF  = 3'h0;
   localparam logic [2:0] GCFG_MAG_MAX  = 3'h5;
   localparam logic [1:0] GCFG_RBV_RSV  = 2'h3;

   localparam int GCFG_IRQ_OVER  = 0;
   localparam int GCFG_IRQ_UNDER = 1;
   localparam int GCFG_IRQ_DC    = 2;
   localparam logic [2:0] GCFG_IRQ_W = 3'h7;

   // Rates in milli-sps, resolutions in nanoseconds, frequency in milli-Hz
   localparam logic [31:0] GCFG_CARD_RATE [4][3] = '{
      '{32'd512000, 32'd256000, 32'd128000},
      '{32'd500000, 32'd250000, 32'd125000},
      '{32'd0, 32'd0, 32'd200000},
      '{32'd0, 32'd0, 32'd199805}};
   localparam logic [31:0] GCFG_IMP_RATE [4][2] = '{
      '{32'd64000, 32'd32000}, '{32'd62500, 32'd31250},
      '{32'd50000, 32'd25000}, '{32'd49950, 32'd24980}};
   localparam logic [31:0] GCFG_BEAT_RES [4] = '{32'd7812500, 32'd8000000,
                                                 32'd8000000, 32'd8008000};
   localparam logic [31:0] GCFG_CALIBRATION_TIME_RESOLUTION [4] = '{32'd30520, 32'd31250,
                                                32'd31250, 32'd31280};
   localparam logic [31:0] GCFG_MSTR_FREQ [4] = '{32'd32768000, 32'd32000000,
                                                  32'd32000000, 32'd31968780};

   typedef struct packed {
      logic       cardiac_channel_enable;
      logic       impedance_channel_enable;
      logic [1:0] impedance_digital_leadoff_select;
      logic [1:0] dc_leadoff_enable;
      logic       leadoff_current_polarity;
      logic [2:0] leadoff_current_magnitude;
      logic [1:0] leadoff_threshold_select;
      logic [1:0] resistive_bias_mode;
      logic [1:0] bias_resistor_value;
      logic       positive_input_bias_connect;
      logic       negative_input_bias_connect;
   } gcfg_ctrl_t;

   typedef struct packed {
      logic       under_detect;
      logic       over_detect;
      logic       dc_detect;
      logic       pullup_pos;
      logic       sources_on;
      logic       bias_card;
      logic       bias_imp;
   } gcfg_analog_t;
endpackage

// file: gcfg_rate_table.sv
// Master clock rate table lookup with registered outputs
`timescale 1ns/1ps
module gcfg_rate_table
   import gcfg_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [1:0]  master_clock_select,
   input  wire logic [1:0]  cardiac_sample_rate_code,
   input  wire logic        impedance_rate_code,
   output logic      [31:0] master_freq_q,
   output logic      [31:0] cardiac_rate_q,
   output logic      [31:0] impedance_rate_q,
   output logic      [31:0] beat_interval_resolution_q,
   output logic      [31:0] calibration_time_resolution_q
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         master_freq_q                 <= '0;
         cardiac_rate_q                <= '0;
         impedance_rate_q              <= '0;
         beat_interval_resolution_q    <= '0;
         calibration_time_resolution_q <= '0;
      end else begin
         master_freq_q <= GCFG_MSTR_FREQ[master_clock_select];
         // Code 11 has no rate; unsupported codes read as zero
         if (cardiac_sample_rate_code == 2'h3) begin
            cardiac_rate_q <= '0;
         end else begin
            cardiac_rate_q <= GCFG_CARD_RATE[master_clock_select][cardiac_sample_rate_code];
         end
         impedance_rate_q              <= GCFG_IMP_RATE[master_clock_select][impedance_rate_code];
         beat_interval_resolution_q    <= GCFG_BEAT_RES[master_clock_select];
         calibration_time_resolution_q <= GCFG_CALIBRATION_TIME_RESOLUTION[master_clock_select];
      end
   end
endmodule

// file: tb_general_config_leadoff_bias.sv
// Self-checking bench for the general configuration register block
`timescale 1ns/1ps
module tb_general_config_leadoff_bias;
   import gcfg_pkg::*;
   logic         pclk;
   logic         presetn;
   logic         psel;
   logic         penable;
   logic         pwrite;
   logic  [11:0] paddr;
   logic  [31:0] pwdata;
   logic  [31:0] prdata;
   logic         pready;
   logic         pslverr;
   logic         ovr_in;
   logic         und_in;
   logic         dc_in;
   gcfg_ctrl_t   ctrl_q;
   gcfg_analog_t analog_q;
   logic         card_pwr;
   logic         imp_pwr;
   logic         beat_ok;
   logic         irq;
   int           n_mismatch;
   int           comparisons;
   logic  [23:0] gen_m;
   logic  [31:0] rd;
   logic         err;

   gcfg_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .imp_over_range_in(ovr_in), .imp_under_range_in(und_in),
      .dc_leadoff_in(dc_in), .ctrl_q(ctrl_q), .analog_q(analog_q),
      .cardiac_power_q(card_pwr), .impedance_power_q(imp_pwr),
      .beat_detect_allowed_q(beat_ok), .irq(irq));

   always #4 pclk = ~pclk;

   task automatic summarize();
      if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   // Setup, then access held until pready; data taken at that same edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) chk(32'h0, 32'h1, "pready never came");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   // Bias mode only sticks when its channel enable is held or written with it
   function automatic logic [23:0] gen_next(logic [23:0] old, logic [31:0] wd);
      logic [23:0] v;
      v = wd[23:0] & 24'h3cffff;
      if (v[5:4] == 2'h1 && !(v[19] || old[19])) v[5:4] = 2'h0;
      if (v[5:4] == 2'h2 && !(v[18] || old[18])) v[5:4] = 2'h0;
      return v;
   endfunction

   // Reserved magnitudes count as sources off
   function automatic logic [6:0] ana_exp(logic [23:0] g);
      logic so;
      so = (g[10:8] != 3'h0) && (g[10:8] <= 3'h5);
      return {g[18] & g[14], g[18] & g[15], g[19] & (g[13:12] == 2'h1), so & ~g[11], so,
              g[19] & (g[5:4] == 2'h1), g[18] & (g[5:4] == 2'h2)};
   endfunction

   task automatic check_gen();
      apb(1'b0, GCFG_ADDR_GENERAL, 32'h0);
      chk(rd, {8'h0, gen_m}, "general readback");
      chk({31'h0, err}, 32'h0, "general error");
      chk({14'h0, ctrl_q}, {14'h0, gen_m[19:18], gen_m[15:0]}, "control copy");
      chk({25'h0, analog_q}, {25'h0, ana_exp(gen_m)}, "analog decode");
      chk({29'h0, card_pwr, imp_pwr, beat_ok}, {29'h0, gen_m[19], gen_m[18], gen_m[19]},
          "channel power");
   endtask

   task automatic wgen(input logic [31:0] d);
      apb(1'b1, GCFG_ADDR_GENERAL, d);
      gen_m = gen_next(gen_m, d);
      repeat (3) @(posedge pclk);
      check_gen();
   endtask

   task automatic pulse(input logic o, input logic u, input logic d);
      @(posedge pclk);
      ovr_in <= o; und_in <= u; dc_in <= d;
      repeat (3) @(posedge pclk);
      ovr_in <= 1'b0; und_in <= 1'b0; dc_in <= 1'b0;
      repeat (5) @(posedge pclk);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string msg);
      apb(1'b0, a, 32'h0);
      chk(rd, exp, msg);
   endtask

   initial begin
      repeat (30000) @(posedge pclk);
      n_mismatch++;
      summarize();
   end

   initial begin
      pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h0; pwdata = 32'h0; ovr_in = 1'b0; und_in = 1'b0; dc_in = 1'b0;
      n_mismatch = 0; comparisons = 0;
      gen_m = 24'h000004;
      void'($urandom(72942));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      check_gen();
      rd_chk(GCFG_ADDR_IRQ_STAT, 32'h0, "status reset");
      rd_chk(GCFG_ADDR_IRQ_MASK, 32'h0, "mask reset");
      // Bias gating corners: off, with enable, enable already held then dropped
      wgen(32'h000014);
      wgen(32'h080014);
      wgen(32'h000024);
      wgen(32'h040004);
      wgen(32'h000024);
      wgen(32'h000034);
      wgen(32'h0c070c);
      wgen(32'h0c0f00);
      for (int i = 0; i < 30; i++) wgen($urandom);
      // Unmapped place refuses; read-only place ignores writes
      apb(1'b1, 12'h0fc, 32'hffffffff);
      chk({31'h0, err}, 32'h1, "unmapped write error");
      apb(1'b0, 12'h0fc, 32'h0);
      chk({rd[31:1], err}, 32'h1, "unmapped read");
      for (int m = 0; m < 4; m++) begin
         for (int c = 0; c < 3; c++) begin
            for (int z = 0; z < 2; z++) begin
               wgen({8'h0, m[1:0], 20'h00004});
               apb(1'b1, GCFG_ADDR_RATE_SEL, {29'h0, z[0], c[1:0]});
               apb(1'b1, GCFG_ADDR_RATE_INFO, 32'hffffffff);
               repeat (2) @(posedge pclk);
               rd_chk(GCFG_ADDR_RATE_INFO, GCFG_CARD_RATE[m][c], "cardiac rate");
               rd_chk(GCFG_ADDR_TIMING, GCFG_BEAT_RES[m], "beat resolution");
               rd_chk(12'h054, GCFG_IMP_RATE[m][z], "impedance rate");
               rd_chk(12'h058, GCFG_MSTR_FREQ[m], "master frequency");
               rd_chk(12'h05c, GCFG_CALIBRATION_TIME_RESOLUTION[m], "calibration resolution");
            end
         end
      end
      // Detectors gated off: no status set; then enabled detectors, mask and write-one-to-clear
      wgen(32'h000004);
      pulse(1'b1, 1'b1, 1'b1);
      rd_chk(GCFG_ADDR_IRQ_STAT, 32'h0, "gated status");
      wgen(32'h0c8004);
      pulse(1'b1, 1'b1, 1'b1);
      rd_chk(GCFG_ADDR_IRQ_STAT, 32'h1, "over only");
      apb(1'b1, GCFG_ADDR_IRQ_STAT, 32'h7);
      wgen(32'h0cd004);
      apb(1'b1, GCFG_ADDR_IRQ_MASK, 32'h4);
      pulse(1'b1, 1'b1, 1'b0);
      rd_chk(GCFG_ADDR_IRQ_STAT, 32'h3, "range flags");
      chk({31'h0, irq}, 32'h0, "masked irq");
      pulse(1'b0, 1'b0, 1'b1);
      rd_chk(GCFG_ADDR_IRQ_STAT, 32'h7, "dc flag");
      chk({31'h0, irq}, 32'h1, "irq raised");
      apb(1'b1, GCFG_ADDR_IRQ_STAT, 32'h5);
      repeat (3) @(posedge pclk);
      rd_chk(GCFG_ADDR_IRQ_STAT, 32'h2, "w1c clear");
      chk({31'h0, irq}, 32'h0, "irq dropped");
      apb(1'b1, GCFG_ADDR_IRQ_MASK, 32'h2);
      repeat (3) @(posedge pclk);
      chk({31'h0, irq}, 32'h1, "unmasked irq");
      apb(1'b1, GCFG_ADDR_IRQ_STAT, 32'h2);
      repeat (3) @(posedge pclk);
      chk({31'h0, irq}, 32'h0, "irq cleared");
      summarize();
   end
endmodule
